// ---- verif/dssq_host_model.sv ----
// far-side host: strobes in direct mode, accept flag in handshake mode
// assumes strobe pins have a pull-up, so a released pin reads high
`timescale 1ns/1ps
module dssq_host_model (
    input wire logic clk,
    input wire logic [1:0] pace,
    input wire logic host_load_n,
    input wire logic host_upper_n,
    input wire logic host_lower_n,
    input wire logic load_n_drv,
    input wire logic load_n_oe,
    input wire logic upper_byte_enable_n_drv,
    input wire logic upper_byte_enable_n_oe,
    input wire logic lower_byte_enable_n_drv,
    input wire logic lower_byte_enable_n_oe,
    output logic far_accept,
    output logic load_n_pin,
    output logic upper_byte_enable_n_pin,
    output logic lower_byte_enable_n_pin
);
    logic [1:0] div = 2'h0;
    always @(posedge clk) begin
        div <= div + 2'h1;
    end
    // slow pacing offers one slot in four, so the device must wait
    assign far_accept = pace[1] | (pace[0] & (div == 2'h3));
    assign load_n_pin = load_n_oe ? load_n_drv : host_load_n;
    assign upper_byte_enable_n_pin = upper_byte_enable_n_oe ? upper_byte_enable_n_drv : host_upper_n;
    assign lower_byte_enable_n_pin = lower_byte_enable_n_oe ? lower_byte_enable_n_drv : host_lower_n;
endmodule : dssq_host_model

// ---- verif/test_dual_slope_conversion_sequencer.sv ----
// bench for the conversion sequencer: random and corner conversions, output modes
// assumes RC clocking for long runs; comparator inputs driven by the bench
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module test_dual_slope_conversion_sequencer;
    import dssq_pkg::*;
    logic clk = 1'b0, rst = 1'b1, osc_rc_select = 1'b1, run = 1'b1, mode = 1'b0;
    logic test_n = 1'b1, integ_positive = 1'b0, zero_cross = 1'b0;
    logic host_load_n = 1'b1, host_upper_n = 1'b1, host_lower_n = 1'b1;
    logic [1:0] pace = 2'h2;
    logic far_accept, load_n_pin, upper_byte_enable_n_pin, lower_byte_enable_n_pin;
    logic load_n_drv, load_n_oe, upper_byte_enable_n_drv, upper_byte_enable_n_oe;
    logic lower_byte_enable_n_drv, lower_byte_enable_n_oe;
    logic status, sign_output, over_limit, low_byte_oe, high_byte_oe;
    logic [CNT_W-1:0] result_bits;
    dssq_sw_t sw;
    int fails = 0, compares = 0, cyc = 0, hb = 0, lb = 0, seed = 43, last = 0;
    dssq_top #(.DIV(XTAL_DIV)) dut (.clk, .rst, .osc_rc_select, .run, .mode, .test_n,
        .integ_positive, .zero_cross, .far_accept, .load_n_pin, .upper_byte_enable_n_pin,
        .lower_byte_enable_n_pin, .load_n_drv, .load_n_oe, .upper_byte_enable_n_drv,
        .upper_byte_enable_n_oe, .lower_byte_enable_n_drv, .lower_byte_enable_n_oe,
        .sw, .status, .result_bits, .sign_output, .over_limit, .low_byte_oe, .high_byte_oe);
    dssq_host_model host (.clk, .pace, .host_load_n, .host_upper_n, .host_lower_n,
        .load_n_drv, .load_n_oe, .upper_byte_enable_n_drv, .upper_byte_enable_n_oe,
        .lower_byte_enable_n_drv, .lower_byte_enable_n_oe, .far_accept, .load_n_pin,
        .upper_byte_enable_n_pin, .lower_byte_enable_n_pin);
    initial forever #50 clk = ~clk;
    task finish_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // counts handshake byte slots only: strobes driven by the device and active
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (high_byte_oe === 1'b1 && upper_byte_enable_n_oe === 1'b1
                && upper_byte_enable_n_drv === 1'b0) hb <= hb + 1;
        if (low_byte_oe === 1'b1 && lower_byte_enable_n_oe === 1'b1
                && lower_byte_enable_n_drv === 1'b0) lb <= lb + 1;
        if (cyc == 95000) begin
            fails++;
            finish_test();
        end
    end
    task wait_rise(input int lim, output int n);
        n = 0;
        while (status !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_rise
    // called at the edge where status is first seen high; tgt < 0 means no crossing
    task conv(input int tgt, input logic pos);
        int k;
        int mag;
        mag = (tgt < 0) ? 4095 : tgt;
        if (last > 0) `CHK("period", 8192, cyc - last)
        last = cyc;
        k = 0;
        integ_positive <= pos;
        while (status === 1'b1 && k < 6200) begin
            if (k == 100) `CHK("integ sw", 4'b0001, sw[6:3])
            if (k == 2100) `CHK("ref sw", {2'b11, pos}, sw[2:0])
            // reference phase starts after loop pass 2047, so the design first
            // sees the crossing on reference tick tgt, with tgt ticks before it
            if (tgt >= 0 && k == 2047 + tgt) zero_cross <= 1'b1;
            @(posedge clk);
            k++;
        end
        zero_cross <= 1'b0;
        // result pins follow the internal latch one clock after status falls
        @(posedge clk);
        `CHK("magnitude", 12'(mag), result_bits)
        `CHK("over", tgt < 0, over_limit)
        `CHK("sign", pos, sign_output)
        `CHK("zero sw", SW_RESET, sw)
    endtask : conv
    initial begin
        int n, i, h0, l0;
        int tl[3];
        tl = '{0, 4095, -1};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wait_rise(50, n);
        `CHK("rc start", 1'b1, n >= 7 && n <= 10)
        for (i = 0; i < 6; i++) begin
            conv((i < 3) ? tl[i] : ({$random(seed)} % 4096), 1'($random(seed)));
            wait_rise(9000, n);
        end
        run <= 1'b0;
        conv({$random(seed)} % 4096, 1'b1);
        wait_rise(9000, n);
        `CHK("held", 9000, n)
        host_load_n <= 1'b0;
        host_upper_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("high direct", 2'b10, {high_byte_oe, low_byte_oe})
        host_upper_n <= 1'b1;
        host_lower_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("low direct", 2'b01, {high_byte_oe, low_byte_oe})
        host_load_n <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("no direct", 2'b00, {high_byte_oe, low_byte_oe})
        host_lower_n <= 1'b1;
        h0 = hb;
        l0 = lb;
        pace <= 2'h0;
        mode <= 1'b1;
        @(posedge clk);
        mode <= 1'b0;
        repeat (40) @(posedge clk);
        `CHK("stalled", {h0, l0, 1'b1}, {hb, lb, load_n_oe})
        pace <= 2'h1;
        repeat (40) @(posedge clk);
        `CHK("pulse bytes", {h0 + 1, l0 + 1, 1'b0}, {hb, lb, load_n_oe})
        pace <= 2'h2;
        mode <= 1'b1;
        repeat (20) @(posedge clk);
        h0 = hb;
        l0 = lb;
        run <= 1'b1;
        last = 0;
        wait_rise(20, n);
        `CHK("resume", 8, n)
        conv({$random(seed)} % 4096, 1'b0);
        repeat (20) @(posedge clk);
        `CHK("auto bytes", {h0 + 1, l0 + 1, 1'b1}, {hb, lb, load_n_oe})
        mode <= 1'b0;
        test_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("test", 14'h3FFF, {sign_output, over_limit, result_bits})
        test_n <= 1'b1;
        osc_rc_select <= 1'b0;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wait_rise(600, n);
        `CHK("xtal start", 1'b1, n >= 400 && n <= 470)
        finish_test();
    end
endmodule : test_dual_slope_conversion_sequencer

// ---- verilog/dssq_clkdiv.sv ----
// converter clock enable from the oscillator clock
// assumes the select input is static or changes only between conversions
`timescale 1ns/1ps
module dssq_clkdiv
    import dssq_pkg::*;
#(
    parameter int DIV = XTAL_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rc_mode,
    output logic tick
);
    logic [6:0] div_cnt;
    wire div_wrap = (div_cnt == 7'(DIV - 1));

    always_ff @(posedge clk) begin
        if (rst || rc_mode || div_wrap) begin
            div_cnt <= 7'h00;
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    // rc mode: every oscillator edge is a converter clock, same phase
    // crystal mode: one enable pulse per DIV oscillator clocks
    always_ff @(posedge clk) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= rc_mode | div_wrap;
        end
    end
endmodule : dssq_clkdiv

// ---- verilog/dssq_pkg.sv ----
// constants and carrier types of the dual-slope conversion sequencer
// assumes one 10 MHz clock, synchronous active-high reset, synchronous pins
package dssq_pkg;
    localparam int CYCLE_LEN = 8192;
    localparam int INT_LEN = 2048;
    localparam int FULL_SCALE = 4096;
    localparam int HOLD_EARLY = 7;
    localparam int XTAL_DIV = 58;
    localparam int CNT_W = 12;
    localparam int POS_W = 13;
    localparam logic [POS_W-1:0] POS_LAST = POS_W'(CYCLE_LEN - 1);
    localparam logic [POS_W-1:0] POS_INT_END = POS_W'(INT_LEN - 1);
    localparam logic [POS_W-1:0] POS_HOLD = POS_W'(CYCLE_LEN - HOLD_EARLY);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FULL_SCALE - 1);
    localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;

    // analog switch controls
    typedef struct packed {
        logic short_inputs;
        logic charge_ref;
        logic az_loop;
        logic connect_inputs;
        logic tie_low_common;
        logic ref_connect;
        logic ref_negative;
    } dssq_sw_t;

    localparam dssq_sw_t SW_RESET = 7'h70;

    typedef struct packed {
        logic sign;
        logic over;
        logic [CNT_W-1:0] mag;
    } dssq_result_t;

    localparam dssq_result_t RESULT_RESET = 14'h0000;
endpackage : dssq_pkg

// ---- verilog/dssq_top.sv ----
// dual-slope conversion sequencer: phase timing, switch controls, result output
// assumes comparator and sign inputs are synchronous to clk; strobes are 3-signal pins
`timescale 1ns/1ps
module dssq_top
    import dssq_pkg::*;
#(
    parameter int DIV = XTAL_DIV
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_rc_select,
    input wire logic run,
    input wire logic mode,
    input wire logic test_n,
    input wire logic integ_positive,
    input wire logic zero_cross,
    input wire logic far_accept,
    input wire logic load_n_pin,
    input wire logic upper_byte_enable_n_pin,
    input wire logic lower_byte_enable_n_pin,
    output logic load_n_drv,
    output logic load_n_oe,
    output logic upper_byte_enable_n_drv,
    output logic upper_byte_enable_n_oe,
    output logic lower_byte_enable_n_drv,
    output logic lower_byte_enable_n_oe,
    output dssq_sw_t sw,
    output logic status,
    output logic [CNT_W-1:0] result_bits,
    output logic sign_output,
    output logic over_limit,
    output logic low_byte_oe,
    output logic high_byte_oe
);
    typedef enum logic [1:0] {ST_ZERO, ST_INT, ST_DEINT} dssq_phase_t;
    typedef enum logic [2:0] {HS_IDLE, HS_WAIT_HI, HS_HI, HS_WAIT_LO, HS_LO} dssq_hs_t;

    logic tick;
    dssq_phase_t state;
    dssq_phase_t next_state;
    dssq_hs_t hs;
    dssq_hs_t next_hs;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] next_pos;
    logic [CNT_W-1:0] de_cnt;
    logic held_sign;
    logic mode_q;
    dssq_result_t res;

    dssq_clkdiv #(
        .DIV(DIV)
    ) u_div (
        .clk(clk),
        .rst(rst),
        .rc_mode(osc_rc_select),
        .tick(tick)
    );

    // phase decoding
    wire int_end = (state == ST_INT) && tick && (pos == POS_INT_END);
    wire de_cross = (state == ST_DEINT) && tick && zero_cross;
    wire de_full = (state == ST_DEINT) && tick && !zero_cross && (de_cnt == CNT_FULL);
    wire de_end = de_cross || de_full;
    wire at_hold = (state == ST_ZERO) && (pos == POS_HOLD) && !run;
    wire cycle_wrap = (state == ST_ZERO) && tick && (pos == POS_LAST);
    // position stops at the hold point while run is low; a cycle under way
    // always completes since hold is only looked at in zeroing
    wire pos_adv = tick && !at_hold;

    always_comb begin
        next_state = state;
        next_pos = pos;
        if (pos_adv) begin
            next_pos = (pos == POS_LAST) ? '0 : pos + POS_W'(1);
        end
        case (state)
            ST_ZERO: begin
                if (cycle_wrap) begin
                    next_state = ST_INT;
                end
            end
            ST_INT: begin
                if (int_end) begin
                    next_state = ST_DEINT;
                end
            end
            ST_DEINT: begin
                // zeroing takes whatever is left of the cycle
                if (de_end) begin
                    next_state = ST_ZERO;
                end
            end
            default: begin
                next_state = ST_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_ZERO;
            pos <= POS_HOLD;
        end else begin
            state <= next_state;
            pos <= next_pos;
        end
    end

    // reference-integrate counter
    always_ff @(posedge clk) begin
        if (rst || int_end) begin
            de_cnt <= CNT_RESET;
        end else if ((state == ST_DEINT) && tick && !de_end) begin
            de_cnt <= de_cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            held_sign <= 1'b0;
        end else if (int_end) begin
            held_sign <= integ_positive;
        end
    end

    // result latch: crossing gives magnitude, full count gives over-limit
    always_ff @(posedge clk) begin
        if (rst) begin
            res <= RESULT_RESET;
        end else if (de_end) begin
            res.mag <= de_cnt;
            res.sign <= held_sign;
            res.over <= de_full;
        end
    end

    // switch controls are registered from the next phase, so they change on the same clock as the phase
    wire is_zero = (next_state == ST_ZERO);
    wire is_int = (next_state == ST_INT);
    wire is_de = (next_state == ST_DEINT);
    dssq_sw_t next_sw;
    assign next_sw.short_inputs = is_zero;
    assign next_sw.charge_ref = is_zero;
    assign next_sw.az_loop = is_zero;
    assign next_sw.connect_inputs = is_int;
    assign next_sw.tie_low_common = is_de;
    assign next_sw.ref_connect = is_de;
    // a positive input is driven back with the reference reversed
    assign next_sw.ref_negative = is_de && (int_end ? integ_positive : held_sign);

    always_ff @(posedge clk) begin
        if (rst) begin
            sw <= SW_RESET;
            status <= 1'b0;
        end else begin
            sw <= next_sw;
            status <= !is_zero;
        end
    end

    // handshake, from idle only: a mode pulse starts at once, held mode starts at each latch
    wire mode_rise = mode && !mode_q;
    wire hs_start = (hs == HS_IDLE) && (mode_rise || (mode && de_end));

    always_comb begin
        next_hs = hs;
        case (hs)
            HS_IDLE: begin
                if (hs_start) begin
                    next_hs = HS_WAIT_HI;
                end
            end
            HS_WAIT_HI: begin
                if (tick && far_accept) begin
                    next_hs = HS_HI;
                end
            end
            HS_HI: begin
                if (tick) begin
                    next_hs = HS_WAIT_LO;
                end
            end
            HS_WAIT_LO: begin
                if (tick && far_accept) begin
                    next_hs = HS_LO;
                end
            end
            HS_LO: begin
                if (tick) begin
                    next_hs = HS_IDLE;
                end
            end
            default: begin
                next_hs = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            hs <= HS_IDLE;
            mode_q <= 1'b0;
        end else begin
            hs <= next_hs;
            mode_q <= mode;
        end
    end

    // strobe pins are outputs while mode is high or a handshake runs
    wire hs_own = mode || (next_hs != HS_IDLE);
    wire hs_hi_slot = (next_hs == HS_HI);
    wire hs_lo_slot = (next_hs == HS_LO);
    // direct mode: host strobes gate the byte drivers; one clock of latency
    wire dir_en = !hs_own && !load_n_pin;
    wire next_hi_oe = hs_own ? hs_hi_slot : (dir_en && !upper_byte_enable_n_pin);
    wire next_lo_oe = hs_own ? hs_lo_slot : (dir_en && !lower_byte_enable_n_pin);

    always_ff @(posedge clk) begin
        if (rst) begin
            load_n_oe <= 1'b0;
            upper_byte_enable_n_oe <= 1'b0;
            lower_byte_enable_n_oe <= 1'b0;
            load_n_drv <= 1'b1;
            upper_byte_enable_n_drv <= 1'b1;
            lower_byte_enable_n_drv <= 1'b1;
            high_byte_oe <= 1'b0;
            low_byte_oe <= 1'b0;
            result_bits <= CNT_RESET;
            sign_output <= 1'b0;
            over_limit <= 1'b0;
        end else begin
            load_n_oe <= hs_own;
            upper_byte_enable_n_oe <= hs_own;
            lower_byte_enable_n_oe <= hs_own;
            load_n_drv <= !(hs_hi_slot || hs_lo_slot);
            upper_byte_enable_n_drv <= !hs_hi_slot;
            lower_byte_enable_n_drv <= !hs_lo_slot;
            high_byte_oe <= next_hi_oe;
            low_byte_oe <= next_lo_oe;
            // test low forces every bit output high
            result_bits <= test_n ? res.mag : '1;
            sign_output <= test_n ? res.sign : 1'b1;
            over_limit <= test_n ? res.over : 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wrap_to_int_a: assert property (cycle_wrap |=> state == ST_INT && pos == '0)
        else $error("cycle end did not start integrate");
    int_from_zero_a: assert property (
        $rose(state == ST_INT) |-> $past(state) == ST_ZERO)
        else $error("integrate entered out of order");
    zero_switches_a: assert property (
        next_state == ST_ZERO |=> sw.short_inputs && sw.az_loop && sw.charge_ref
            && !sw.connect_inputs)
        else $error("zeroing switches wrong");
    int_length_a: assert property (state == ST_INT && !int_end |=> state == ST_INT)
        else $error("integrate left early");
    int_end_a: assert property (
        int_end |=> state == ST_DEINT && pos == POS_W'(INT_LEN))
        else $error("integrate length wrong");
    sign_held_a: assert property (int_end |=> held_sign == $past(integ_positive))
        else $error("sign not held");
    ref_polarity_a: assert property (
        state == ST_DEINT ##1 state == ST_DEINT
            |-> sw.ref_connect && sw.tie_low_common && sw.ref_negative == held_sign)
        else $error("reference polarity wrong");
    magnitude_a: assert property (de_cross |=> res.mag == $past(de_cnt) && !res.over)
        else $error("magnitude not latched");
    hold_point_a: assert property (at_hold |=> state == ST_ZERO && pos == POS_HOLD)
        else $error("hold point not kept");
    status_zero_a: assert property (state == ST_ZERO |-> !status)
        else $error("status high in zeroing");
    over_set_a: assert property (
        de_full |=> res.over && res.mag == CNT_FULL ##1 (over_limit || !test_n))
        else $error("over-limit not set");
    strobe_drive_a: assert property (mode |=> load_n_oe && upper_byte_enable_n_oe)
        else $error("strobes not driven");
    status_int_a: assert property (state != ST_ZERO |-> status)
        else $error("status low while integrating");
    latch_out_a: assert property (
        test_n |=> over_limit == $past(res.over) && sign_output == $past(res.sign))
        else $error("result flags not passed out");
    rc_tick_a: assert property (osc_rc_select |=> tick)
        else $error("rc clock enable missing");
    xtal_tick_a: assert property (!osc_rc_select && tick |=> !tick)
        else $error("crystal clock enable too wide");
    hs_start_a: assert property (hs_start |=> hs == HS_WAIT_HI && load_n_oe)
        else $error("handshake did not start");
    hs_pacing_a: assert property (
        hs == HS_WAIT_HI && !(tick && far_accept) |=> hs == HS_WAIT_HI)
        else $error("byte sent without accept");
    hi_slot_a: assert property (
        hs == HS_HI |-> high_byte_oe && !upper_byte_enable_n_drv && !load_n_drv)
        else $error("high byte slot wrong");
    lo_slot_a: assert property (
        hs == HS_LO |-> low_byte_oe && !lower_byte_enable_n_drv && !load_n_drv)
        else $error("low byte slot wrong");
    direct_gate_a: assert property (
        !load_n_oe && high_byte_oe |-> $past(!load_n_pin) && $past(!upper_byte_enable_n_pin))
        else $error("direct high byte gate wrong");

    overrange_c: cover property (de_full);
    hold_c: cover property (at_hold ##1 run);
    handshake_c: cover property (hs == HS_LO ##1 hs == HS_IDLE);
    pulse_start_c: cover property (mode_rise && !mode_q ##1 !mode);
    auto_hs_c: cover property (mode && de_end);
endmodule : dssq_top
